// >>> core/preset_speed_pkg.sv
// package: register map, reset values, encodings and state record of the preset speed selector
package preset_speed_pkg;

    // register byte offsets
    localparam logic [7:0]  PRESET_BASE_OFS = 8'h00;   // speed k at PRESET_BASE_OFS + 4*(k-1), k = 1..15
    localparam logic [7:0]  CTRL_OFS        = 8'h40;
    localparam logic [7:0]  JOG_FREQ_OFS    = 8'h44;
    localparam logic [7:0]  TERM_FN_OFS     = 8'h48;
    localparam logic [7:0]  STATUS_OFS      = 8'h4C;

    // frequency values in 0.1 Hz steps
    localparam logic [15:0] FREQ_MAX        = 16'h0FA0;   // 400.0 Hz
    localparam logic [15:0] FREQ_UNSET      = 16'h270F;   // 9999, preset not selected
    localparam logic [15:0] HIGH_RST        = 16'h0258;   // 60.0 Hz
    localparam logic [15:0] MID_RST         = 16'h012C;   // 30.0 Hz
    localparam logic [15:0] LOW_RST         = 16'h0064;   // 10.0 Hz
    localparam logic [15:0] JOG_RST         = 16'h0032;   // 5.0 Hz
    localparam logic [15:0][15:0] PRESET_RST = {{12{FREQ_UNSET}}, LOW_RST, MID_RST, HIGH_RST, 16'h0000};

    // preset index of the three basic speeds
    localparam logic [3:0]  IDX_HIGH        = 4'h1;
    localparam logic [3:0]  IDX_MID         = 4'h2;
    localparam logic [3:0]  IDX_LOW         = 4'h3;

    // control register fields
    localparam int          CTRL_MODE_LSB   = 0;          // operation mode, 4 bits
    localparam int          CTRL_REMOTE_LSB = 4;          // remote function selection, 2 bits
    localparam int          CTRL_COMP_BIT   = 8;          // analog compensation enable
    localparam int          CTRL_JOG_BIT    = 9;          // jog enable
    localparam logic [3:0]  MODE_EXT        = 4'h3;
    localparam logic [3:0]  MODE_COMBINED   = 4'h4;
    localparam logic [3:0]  MODE_RST        = 4'h3;
    localparam logic [1:0]  REMOTE_RST      = 2'h0;

    // terminal function codes, 4 bits per terminal
    localparam int          N_TERM          = 6;
    localparam logic [3:0]  FN_LOW          = 4'h0;
    localparam logic [3:0]  FN_MID          = 4'h1;
    localparam logic [3:0]  FN_HIGH         = 4'h2;
    localparam logic [3:0]  FN_EXT          = 4'h8;
    localparam logic [23:0] TERM_FN_RST     = 24'hFF_8210;

    typedef enum logic [2:0] {
        SRC_NONE   = 3'b000,
        SRC_JOG    = 3'b001,
        SRC_PRESET = 3'b010,
        SRC_AIN4   = 3'b011,
        SRC_AIN2   = 3'b100
    } src_t;

    // analog command from the converter logic
    typedef struct packed {
        logic        valid;
        logic [15:0] freq;
    } ain_t;

    typedef struct packed {
        logic [15:0][15:0]   preset;
        logic [3:0]          mode;
        logic [1:0]          remote;
        logic                comp_en;
        logic                jog_en;
        logic [15:0]         jog_freq;
        logic [23:0]         term_fn;
        logic [N_TERM-1:0]   term_s1;
        logic [N_TERM-1:0]   term_s2;
        logic                jog_s1;
        logic                jog_s2;
        logic                pready;
        logic                pslverr;
        logic [31:0]         prdata;
        logic [15:0]         freq;
        src_t                src;
        logic [3:0]          speed;
    } state_t;

    localparam state_t STATE_RST = '{
        preset: PRESET_RST, mode: MODE_RST, remote: REMOTE_RST, comp_en: 1'b0, jog_en: 1'b1,
        jog_freq: JOG_RST, term_fn: TERM_FN_RST, term_s1: '0, term_s2: '0, jog_s1: 1'b0,
        jog_s2: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000, freq: 16'h0000,
        src: SRC_NONE, speed: 4'h0};

endpackage : preset_speed_pkg

// >>> core/preset_speed_selector.sv
// preset speed selector: contact-select decode, source priority and apb register file
//
// Functional notes
// R1: single high/middle/low input picks its preset
// R2: basic presets 0-400Hz, reset 60/30/10Hz
// R3: several basic inputs: lower speed preset wins
// R4: input combinations address twelve extra presets
// R5: extra presets reset to 9999, meaning unset
// R6: speed 8 unset, extension only: low
// R7: priority jog, preset, terminal 4, terminal 2
// R8: presets only in operation mode 3 or 4
// R9: nonzero remote selection disables preset selection
// R10: presets writable at any time, any mode
// R11: analog compensation only when compensation bit set
// R12: terminal function codes 0,1,2,8 map selects
// R13: extra presets equal rank, one per combination
// R14: binary weighting, extension input most significant
// R15: nothing selected or unset: fall through; an unset extra falls back to a basic preset instead
module preset_speed_selector (
    // clock and reset
    input  wire logic                                 pclk,
    input  wire logic                                 presetn,
    // apb slave
    input  wire logic                                 psel,
    input  wire logic                                 penable,
    input  wire logic                                 pwrite,
    input  wire logic [7:0]                           paddr,
    input  wire logic [31:0]                          pwdata,
    input  wire logic [3:0]                           pstrb,
    output logic                                      pready,
    output logic                                      pslverr,
    output logic [31:0]                               prdata,
    // contact inputs from pins
    input  wire logic [preset_speed_pkg::N_TERM-1:0]  term_in,
    input  wire logic                                 jog_in,
    // analog commands and compensation, same clock
    input  preset_speed_pkg::ain_t                    ain4,
    input  preset_speed_pkg::ain_t                    ain2,
    input  wire logic signed [15:0]                   comp_in,
    // running frequency command
    output logic [15:0]                               freq_cmd,
    output preset_speed_pkg::src_t                    freq_src,
    output logic [3:0]                                speed_sel
);
    import preset_speed_pkg::*;

    state_t                q;
    state_t                d;
    logic [N_TERM-1:0]     hit_low;
    logic [N_TERM-1:0]     hit_mid;
    logic [N_TERM-1:0]     hit_high;
    logic [N_TERM-1:0]     hit_ext;
    logic [3:0]            sel;
    logic                  jog_act;
    logic                  preset_ok;
    logic [5:0]            word;
    logic                  is_preset;
    logic [3:0]            wr_idx;
    logic                  acc_err;
    logic [31:0]           rd_data;
    logic [3:0]            basic_idx;
    logic [3:0]            extra_idx;
    logic [3:0]            pick_idx;
    logic                  pick_ok;
    logic signed [16:0]    comp_sum;
    logic [15:0]           pick_freq;

    // any terminal carries any select through its function code [R12]
    for (genvar t = 0; t < N_TERM; t++) begin : g_term
        assign hit_low[t]  = q.term_s2[t] && (q.term_fn[t*4 +: 4] == FN_LOW);   // [R12]
        assign hit_mid[t]  = q.term_s2[t] && (q.term_fn[t*4 +: 4] == FN_MID);
        assign hit_high[t] = q.term_s2[t] && (q.term_fn[t*4 +: 4] == FN_HIGH);
        assign hit_ext[t]  = q.term_s2[t] && (q.term_fn[t*4 +: 4] == FN_EXT);
    end

    // extension is the top bit of the combination code [R14]
    assign sel       = {|hit_ext, |hit_high, |hit_mid, |hit_low};
    assign jog_act   = q.jog_en && q.jog_s2;
    // mode and remote gating of the preset path [R8] [R9]
    assign preset_ok = ((q.mode == MODE_EXT) || (q.mode == MODE_COMBINED)) && (q.remote == 2'h0);

    // address decode, one aligned word per register
    assign word      = paddr[7:2];
    assign is_preset = (paddr < CTRL_OFS) && (word != 6'h0F);
    assign wr_idx    = word[3:0] + 4'h1;

    // read mux and refusal of unmapped, read-only, partial or out-of-range access
    always_comb begin
        rd_data = 32'h0000_0000;
        acc_err = 1'b0;
        if (is_preset) begin
            rd_data = {16'h0000, q.preset[wr_idx]};
            // basic presets take no unset marker; extras do [R2] [R5]
            if (pwrite && (pwdata[15:0] > FREQ_MAX) && !((wr_idx > IDX_LOW) && (pwdata[15:0] == FREQ_UNSET))) begin
                acc_err = 1'b1;
            end
        end else if (paddr == CTRL_OFS) begin
            rd_data = {22'h00_0000, q.jog_en, q.comp_en, 2'h0, q.remote, q.mode};
        end else if (paddr == JOG_FREQ_OFS) begin
            rd_data = {16'h0000, q.jog_freq};
            acc_err = pwrite && (pwdata[15:0] > FREQ_MAX);
        end else if (paddr == TERM_FN_OFS) begin
            rd_data = {8'h00, q.term_fn};
        end else if (paddr == STATUS_OFS) begin
            rd_data = {4'h0, sel, q.speed, 1'b0, q.src, q.freq};
            acc_err = pwrite;
        end else begin
            acc_err = 1'b1;
        end
        if (pwrite && (pstrb != 4'hF)) begin
            acc_err = 1'b1;
        end
    end

    // basic select: the lower speed input wins [R1] [R3]
    always_comb begin
        if (sel[0]) begin
            basic_idx = IDX_LOW;
        end else if (sel[1]) begin
            basic_idx = IDX_MID;
        end else if (sel[2]) begin
            basic_idx = IDX_HIGH;
        end else begin
            basic_idx = 4'h0;
        end
    end

    // combination code to speed 4..15, one preset per code, no ranking [R4] [R13] [R14]
    assign extra_idx = (sel == 4'h3) ? 4'h4 : sel;

    // preset choice with fall-back to basic when the extra preset is unset
    always_comb begin
        pick_idx = 4'h0;
        pick_ok  = 1'b0;
        case (sel)
            4'h0: begin
                pick_ok = 1'b0;                                   // [R15]
            end
            4'h1, 4'h2, 4'h4: begin
                pick_idx = basic_idx;                             // [R1]
                pick_ok  = 1'b1;
            end
            default: begin
                if (q.preset[extra_idx] != FREQ_UNSET) begin
                    pick_idx = extra_idx;                         // [R4]
                    pick_ok  = 1'b1;
                end else if (sel[2:0] != 3'h0) begin
                    pick_idx = basic_idx;                         // [R3] [R5]
                    pick_ok  = 1'b1;
                end else begin
                    pick_idx = IDX_LOW;                           // [R6]
                    pick_ok  = 1'b1;
                end
            end
        endcase
    end

    // compensation clamps into 0..400Hz; without the bit the preset passes untouched [R11]
    assign comp_sum = $signed({1'b0, q.preset[pick_idx]}) + 17'(comp_in);
    always_comb begin
        if (!q.comp_en) begin
            pick_freq = q.preset[pick_idx];                       // [R11]
        end else if (comp_sum < 17'sd0) begin
            pick_freq = 16'h0000;
        end else if (comp_sum > $signed({1'b0, FREQ_MAX})) begin
            pick_freq = FREQ_MAX;
        end else begin
            pick_freq = comp_sum[15:0];
        end
    end

    // next state: synchronisers, apb slave, command source priority
    always_comb begin
        d         = q;
        d.term_s1 = term_in;
        d.term_s2 = q.term_s1;
        d.jog_s1  = jog_in;
        d.jog_s2  = q.jog_s1;
        // one wait state; answer latched so outputs come from flops
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        if (psel && penable && !q.pready) begin
            d.pready  = 1'b1;
            d.pslverr = acc_err;
            d.prdata  = pwrite ? 32'h0000_0000 : rd_data;
        end
        // writes land at the completing edge; no lock by mode or run state [R10]
        if (psel && penable && q.pready && pwrite && !q.pslverr) begin
            if (is_preset) begin
                d.preset[wr_idx] = pwdata[15:0];                  // [R10]
            end else if (paddr == CTRL_OFS) begin
                d.mode    = pwdata[CTRL_MODE_LSB +: 4];
                d.remote  = pwdata[CTRL_REMOTE_LSB +: 2];
                d.comp_en = pwdata[CTRL_COMP_BIT];
                d.jog_en  = pwdata[CTRL_JOG_BIT];
            end else if (paddr == JOG_FREQ_OFS) begin
                d.jog_freq = pwdata[15:0];
            end else if (paddr == TERM_FN_OFS) begin
                d.term_fn = pwdata[23:0];
            end
        end
        // jog, then presets, then terminal 4, then terminal 2 [R7]
        d.speed = 4'h0;
        if (jog_act) begin
            d.src  = SRC_JOG;                                     // [R7]
            d.freq = q.jog_freq;
        end else if (preset_ok && pick_ok) begin
            d.src   = SRC_PRESET;                                 // [R8] [R9]
            d.freq  = pick_freq;
            d.speed = (pick_idx == IDX_HIGH) ? 4'h1 : (pick_idx == IDX_MID) ? 4'h2 :
                      (pick_idx == IDX_LOW) ? 4'h3 : pick_idx;
        end else if (ain4.valid) begin
            d.src  = SRC_AIN4;                                    // [R15]
            d.freq = ain4.freq;
        end else if (ain2.valid) begin
            d.src  = SRC_AIN2;
            d.freq = ain2.freq;
        end else begin
            d.src  = SRC_NONE;
            d.freq = 16'h0000;
        end
    end

    // all state in one register; reset loads constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= STATE_RST;                                       // [R2] [R5]
        end else begin
            q <= d;
        end
    end

    assign pready    = q.pready;
    assign pslverr   = q.pslverr;
    assign prdata    = q.prdata;
    assign freq_cmd  = q.freq;
    assign freq_src  = q.src;
    assign speed_sel = q.speed;

    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wait_state;
        psel && penable && !pready;
    endsequence

    sequence s_done_write;
        psel && penable && pready && pwrite && !pslverr;
    endsequence

    sequence s_refused_write;
        psel && penable && pready && pwrite && pslverr;
    endsequence

    logic plain_preset;
    assign plain_preset = !jog_act && preset_ok && !q.comp_en;

    a_apb_one_wait: assert property (s_wait_state |=> pready ##1 !pready)
        else $error("apb answer not exactly one cycle after wait");
    a_preset_write: assert property (s_done_write and (is_preset && !jog_act) |=> // [R10]
        q.preset[$past(wr_idx)] == $past(pwdata[15:0]))
        else $error("preset write lost");
    a_jog_first: assert property (jog_act |=> freq_src == SRC_JOG && freq_cmd == $past(q.jog_freq)) // [R7]
        else $error("jog did not take priority");
    a_high_only: assert property (plain_preset && sel == 4'h4 |=> // [R1]
        freq_cmd == $past(q.preset[1]) && speed_sel == 4'h1)
        else $error("high select did not run high preset");
    a_lower_wins: assert property (plain_preset && sel == 4'h6 && q.preset[6] == FREQ_UNSET |=> // [R3]
        freq_cmd == $past(q.preset[2]))
        else $error("middle did not win over high");
    a_ext_only_low: assert property (plain_preset && sel == 4'h8 && q.preset[8] == FREQ_UNSET |=> // [R6]
        freq_cmd == $past(q.preset[3]))
        else $error("extension only did not fall to low preset");
    a_extra_map: assert property (plain_preset && sel == 4'h9 && q.preset[9] != FREQ_UNSET |=> // [R4]
        speed_sel == 4'h9 && freq_cmd == $past(q.preset[9]))
        else $error("combination did not address its preset");
    a_mode_gate: assert property (!jog_act && !((q.mode == MODE_EXT) || (q.mode == MODE_COMBINED)) |=> // [R8]
        freq_src != SRC_PRESET)
        else $error("preset active outside modes 3 and 4");
    a_remote_gate: assert property (q.remote != 2'h0 |=> freq_src != SRC_PRESET) // [R9]
        else $error("preset active with remote function set");
    a_fall_through: assert property (!jog_act && sel == 4'h0 && ain4.valid |=> // [R15]
        freq_src == SRC_AIN4 && freq_cmd == $past(ain4.freq))
        else $error("no fall through to terminal 4");

    a_mid_only: assert property (plain_preset && sel == 4'h2 |=> // [R1]
        freq_cmd == $past(q.preset[2]) && speed_sel == 4'h2)
        else $error("middle select did not run middle preset");

    a_low_only: assert property (plain_preset && sel == 4'h1 |=> // [R1]
        freq_cmd == $past(q.preset[3]) && speed_sel == 4'h3)
        else $error("low select did not run low preset");

    a_low_over_all: assert property (plain_preset && sel == 4'h7 && q.preset[7] == FREQ_UNSET |=> // [R3]
        freq_cmd == $past(q.preset[3]) && speed_sel == 4'h3)
        else $error("low did not win over middle and high");

    a_code_three: assert property (plain_preset && sel == 4'h3 && q.preset[4] != FREQ_UNSET |=> // [R14]
        freq_cmd == $past(q.preset[4]) && speed_sel == 4'h4)
        else $error("low and middle did not address speed 4");

    a_extra_unset: assert property (plain_preset && sel[2:0] != 3'h0 && q.preset[sel] == FREQ_UNSET |=> // [R5]
        speed_sel == 4'h1 || speed_sel == 4'h2 || speed_sel == 4'h3)
        else $error("unset extra preset was selected");

    a_preset_over_ain: assert property (!jog_act && preset_ok && sel != 4'h0 |=> freq_src == SRC_PRESET) // [R7]
        else $error("analog input overrode preset selection");

    a_ain2_last: assert property (!jog_act && !(preset_ok && sel != 4'h0) && !ain4.valid && ain2.valid |=> // [R7]
        freq_src == SRC_AIN2 && freq_cmd == $past(ain2.freq))
        else $error("terminal 2 not used as last source");

    a_no_source: assert property (!jog_act && !(preset_ok && sel != 4'h0) && !ain4.valid && !ain2.valid |=> // [R15]
        freq_src == SRC_NONE && freq_cmd == 16'h0000)
        else $error("command present with no source");

    a_freq_range: assert property (freq_src == SRC_PRESET |-> freq_cmd <= FREQ_MAX) // [R2] [R11]
        else $error("preset command above 400 Hz");

    a_comp_floor: assert property (q.comp_en && !jog_act && preset_ok && sel == 4'h4 && // [R11]
        comp_in < -$signed({1'b0, q.preset[1]}) |=> freq_cmd == 16'h0000)
        else $error("compensated preset not clamped at zero");

    a_combined_mode: assert property (!jog_act && !q.comp_en && q.mode == MODE_COMBINED && // [R8]
        q.remote == 2'h0 && sel == 4'h4 |=> freq_src == SRC_PRESET && freq_cmd == $past(q.preset[1]))
        else $error("preset not used in combined mode");

    a_status_ro: assert property (s_wait_state and (pwrite && paddr == STATUS_OFS) |=> pslverr)
        else $error("status write not refused");

    a_refused_keep: assert property (s_refused_write and (is_preset) |=> // [R2]
        q.preset[$past(wr_idx)] == $past(q.preset[wr_idx]))
        else $error("refused write changed a preset");

    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error flag outside an answer");

    a_unset_taken: assert property (s_wait_state and (pwrite && is_preset && wr_idx > IDX_LOW && // [R5]
        pstrb == 4'hF && pwdata[15:0] == FREQ_UNSET) |=> !pslverr)
        else $error("unset marker refused for extra preset");

    a_ctrl_write: assert property (s_done_write and (paddr == CTRL_OFS) |=> // [R8] [R9]
        q.mode == $past(pwdata[CTRL_MODE_LSB +: 4]) && q.remote == $past(pwdata[CTRL_REMOTE_LSB +: 2]))
        else $error("control write lost");

endmodule : preset_speed_selector

// >>> tb/contact_switches.sv
// contact switch model: select terminals and jog contact seen by the selector
module contact_switches (
    // clock
    input  wire logic       pclk,
    // wanted contact states
    input  wire logic [5:0] close_req,
    input  wire logic       jog_req,
    // pins to the selector
    output logic [5:0]      term_in = 6'h00,
    output logic            jog_in = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // contacts move just after an edge, as a clocked controller output would
    always @(posedge pclk) begin
        term_in <= close_req;
        jog_in  <= jog_req;
    end
endmodule : contact_switches

// >>> tb/preset_speed_selector_bench.sv
// self-checking bench for the preset speed selector
module preset_speed_selector_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import preset_speed_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [3:0]  pstrb = 4'hF, speed_sel;
    logic        pready, pslverr, jog_in, jog_req = 1'b0, er;
    logic [5:0]  term_in, close_req = 6'h00;
    ain_t        ain4 = '0, ain2 = '0;
    logic signed [15:0] comp_in = 16'sh0000;
    logic [15:0] freq_cmd;
    src_t        freq_src;
    int          miscompares = 0, tests_run = 0;

    // 20 MHz clock
    always #25 pclk = ~pclk;

    preset_speed_selector preset_speed_selector_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .term_in(term_in), .jog_in(jog_in), .ain4(ain4), .ain2(ain2),
        .comp_in(comp_in), .freq_cmd(freq_cmd), .freq_src(freq_src), .speed_sel(speed_sel));

    contact_switches contact_switches_i (
        .pclk(pclk), .close_req(close_req), .jog_req(jog_req), .term_in(term_in), .jog_in(jog_in));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer; waits for pready (a hang is left to the watchdog), then releases
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0000_0000);
        chk({31'h0, er}, {31'h0, e});
        if (!e) chk(rd, exp);
    endtask : rchk

    // close contacts, let the two sync stages and the output register pass, then judge
    task automatic go(input logic [5:0] p, input logic j, input logic [15:0] f, input src_t s, input logic [3:0] k);
        @(posedge pclk);
        close_req <= p; jog_req <= j;
        repeat (6) @(posedge pclk);
        @(negedge pclk);
        chk({16'h0, freq_cmd}, {16'h0, f});
        chk({29'h0, freq_src}, {29'h0, s});
        chk({28'h0, speed_sel}, {28'h0, k});
    endtask : go

    task automatic t_reset;
        rchk(8'h00, 32'h0000_0258, 1'b0);
        rchk(8'h04, 32'h0000_012C, 1'b0);
        rchk(8'h08, 32'h0000_0064, 1'b0);
        for (int k = 4; k <= 15; k++) rchk(8'(4 * (k - 1)), 32'h0000_270F, 1'b0);
        rchk(CTRL_OFS, 32'h0000_0203, 1'b0);
        rchk(JOG_FREQ_OFS, 32'h0000_0032, 1'b0);
        rchk(TERM_FN_OFS, 32'h00FF_8210, 1'b0);
        go(6'h00, 1'b0, 16'h0000, SRC_NONE, 4'h0);
        go(6'h08, 1'b0, 16'h0064, SRC_PRESET, 4'h3);
        $display("test reset values done");
    endtask : t_reset

    task automatic t_basic;
        go(6'h04, 1'b0, 16'h0258, SRC_PRESET, 4'h1);
        go(6'h02, 1'b0, 16'h012C, SRC_PRESET, 4'h2);
        go(6'h01, 1'b0, 16'h0064, SRC_PRESET, 4'h3);
        go(6'h06, 1'b0, 16'h012C, SRC_PRESET, 4'h2);
        go(6'h07, 1'b0, 16'h0064, SRC_PRESET, 4'h3);
        $display("test basic selects done");
    endtask : t_basic

    // every combination addresses its own extra preset, each loaded with a distinct value
    task automatic t_extra;
        int sp;
        for (int k = 4; k <= 15; k++) apb(1'b1, 8'(4 * (k - 1)), 32'(1000 + 10 * k));
        for (int c = 3; c <= 15; c++) begin
            if (c != 4) begin
                sp = (c == 3) ? 4 : c;
                go(6'(c), 1'b0, 16'(1000 + 10 * sp), SRC_PRESET, 4'(sp));
            end
        end
        apb(1'b1, 8'h1C, 32'h0000_270F);
        chk({31'h0, er}, 32'h0);
        go(6'h08, 1'b0, 16'h0064, SRC_PRESET, 4'h3);
        $display("test extra presets done");
    endtask : t_extra

    task automatic t_source;
        @(posedge pclk);
        ain4 <= '{valid: 1'b1, freq: 16'h04D2};
        ain2 <= '{valid: 1'b1, freq: 16'h0309};
        go(6'h00, 1'b0, 16'h04D2, SRC_AIN4, 4'h0);
        go(6'h04, 1'b0, 16'h0258, SRC_PRESET, 4'h1);
        go(6'h04, 1'b1, 16'h0032, SRC_JOG, 4'h0);
        apb(1'b1, CTRL_OFS, 32'h0000_0201);
        go(6'h04, 1'b0, 16'h04D2, SRC_AIN4, 4'h0);
        apb(1'b1, 8'h00, 32'h0000_028A);
        rchk(8'h00, 32'h0000_028A, 1'b0);
        apb(1'b1, CTRL_OFS, 32'h0000_0204);
        go(6'h04, 1'b0, 16'h028A, SRC_PRESET, 4'h1);
        apb(1'b1, CTRL_OFS, 32'h0000_0213);
        go(6'h04, 1'b0, 16'h04D2, SRC_AIN4, 4'h0);
        apb(1'b1, CTRL_OFS, 32'h0000_0203);
        @(posedge pclk);
        ain4 <= '0;
        go(6'h00, 1'b0, 16'h0309, SRC_AIN2, 4'h0);
        @(posedge pclk);
        ain2 <= '0;
        go(6'h00, 1'b0, 16'h0000, SRC_NONE, 4'h0);
        $display("test source priority done");
    endtask : t_source

    task automatic t_comp;
        @(posedge pclk);
        comp_in <= 16'sd50;
        go(6'h04, 1'b0, 16'h028A, SRC_PRESET, 4'h1);
        apb(1'b1, CTRL_OFS, 32'h0000_0303);
        go(6'h04, 1'b0, 16'h02BC, SRC_PRESET, 4'h1);
        @(posedge pclk);
        comp_in <= -16'sd800;
        go(6'h04, 1'b0, 16'h0000, SRC_PRESET, 4'h1);
        apb(1'b1, CTRL_OFS, 32'h0000_0203);
        @(posedge pclk);
        comp_in <= 16'sh0000;
        $display("test compensation done");
    endtask : t_comp

    task automatic t_remap_refuse;
        apb(1'b1, TERM_FN_OFS, 32'h00F2_8210);
        go(6'h10, 1'b0, 16'h028A, SRC_PRESET, 4'h1);
        rchk(STATUS_OFS, 32'h0412_028A, 1'b0);
        go(6'h00, 1'b0, 16'h0000, SRC_NONE, 4'h0);
        rchk(8'h3C, 32'h0, 1'b1);
        apb(1'b1, 8'h00, 32'h0000_0FA1);
        chk({31'h0, er}, 32'h1);
        rchk(8'h00, 32'h0000_028A, 1'b0);
        apb(1'b1, STATUS_OFS, 32'h0000_0001);
        chk({31'h0, er}, 32'h1);
        pstrb <= 4'h7;
        apb(1'b1, 8'h04, 32'h0000_0001);
        chk({31'h0, er}, 32'h1);
        pstrb <= 4'hF;
        rchk(8'h04, 32'h0000_012C, 1'b0);
        $display("test remap and refusals done");
    endtask : t_remap_refuse

    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run

    // main sequence: 12-cycle reset, then each scenario in turn
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_basic();
        t_extra();
        t_source();
        t_comp();
        t_remap_refuse();
        complete_run();
    end

    // watchdog: whole run needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        complete_run();
    end
endmodule : preset_speed_selector_bench
